// File: pkg/mau_pkg.sv
package mau_pkg;

  // Datapath and modifier widths
  localparam int MAU_ADDR_W = 16;
  localparam int MAU_SIZE_W = 14;

  // Modifier field positions
  localparam int MAU_SIZE_LSB = 0;
  localparam int MAU_SIZE_MSB = 13;
  localparam int MAU_SEL_LSB = 14;
  localparam int MAU_SEL_MSB = 15;

  // Arithmetic selection held in the top two modifier bits
  localparam logic [1:0] MAU_SEL_FIRST = 2'h0;
  localparam logic [1:0] MAU_SEL_RSVD = 2'h1;
  localparam logic [1:0] MAU_SEL_BOTH = 2'h2;
  localparam logic [1:0] MAU_SEL_LINEAR = 2'h3;

  // Size field values with a special meaning
  localparam logic [13:0] MAU_SIZE_ZERO = 14'h0000;
  localparam logic [13:0] MAU_SIZE_FULL = 14'h3fff;

  // Modifier value after reset: linear updates for every pointer
  localparam logic [15:0] MAU_MOD_RESET = 16'hffff;

  // Pointer register numbers; only the first two may wrap
  localparam logic [1:0] MAU_FIRST_POINTER = 2'h0;
  localparam logic [1:0] MAU_SECOND_POINTER = 2'h1;

  // Step values for the unit updates
  localparam logic [15:0] MAU_STEP_INC = 16'h0001;
  localparam logic [15:0] MAU_STEP_DEC = 16'hffff;
  localparam logic [15:0] MAU_STEP_NONE = 16'h0000;

  // Cycles from a taken request to its answer
  localparam int MAU_LATENCY = 1;

  // Register-indirect addressing modes
  typedef enum logic [2:0] {
    MAU_MODE_INDIRECT = 3'h0,
    MAU_MODE_POST_INC = 3'h1,
    MAU_MODE_POST_DEC = 3'h2,
    MAU_MODE_POST_ADD = 3'h3,
    MAU_MODE_INDEX_OFS = 3'h4,
    MAU_MODE_INDEX_IMM = 3'h5
  } mau_mode_e;

  // Address request from the execution pipeline
  typedef struct packed {
    logic valid;
    logic [1:0] ptr_sel;
    mau_mode_e mode;
    logic [15:0] pointer;
    logic [15:0] offset;
  } mau_req_s;

  // Answer returned to the pipeline
  typedef struct packed {
    logic valid;
    logic [15:0] address;
    logic [15:0] pointer;
    logic write_back;
    logic modulo;
    logic wrap_up;
    logic wrap_down;
  } mau_ans_s;

  // Whole state of the top module
  typedef struct packed {
    logic [15:0] modifier;
    logic reserved;
    mau_ans_s ans;
  } mau_state_s;

  localparam mau_state_s MAU_STATE_RESET = '{
    modifier: MAU_MOD_RESET,
    reserved: 1'b0,
    ans: '0
  };

endpackage : mau_pkg

// File: rtl/mau_size_mask.sv
`timescale 1ns/1ns
// Turns size minus one into the 2^k - 1 mask of the bits a wrap may change
module mau_size_mask
  import mau_pkg::*;
(
  // Size field of the modifier
  input wire logic [MAU_SIZE_W-1:0] size_m1_in,
  // Low k bits set
  output logic [MAU_ADDR_W-1:0] mask_out
);

  // Bit i is set when any size bit at or above i is set, giving 2^k >= size
  genvar i;
  generate
    for (i = 0; i < MAU_SIZE_W; i = i + 1) begin : g_smear
      assign mask_out[i] = |size_m1_in[MAU_SIZE_W-1:i];
    end
  endgenerate

  // Buffers never exceed fourteen address bits
  assign mask_out[MAU_ADDR_W-1:MAU_SIZE_W] = '0;

endmodule : mau_size_mask

// File: rtl/mau_wrap_adder.sv
`timescale 1ns/1ns
// Adds an offset to the low k bits of a pointer and folds the result once
module mau_wrap_adder
  import mau_pkg::*;
(
  // Operands
  input wire logic [MAU_ADDR_W-1:0] pointer_in,
  input wire logic [MAU_ADDR_W-1:0] offset_in,
  input wire logic [MAU_SIZE_W-1:0] size_m1_in,
  input wire logic [MAU_ADDR_W-1:0] mask_in,
  // Result and fold direction
  output logic [MAU_ADDR_W-1:0] result_out,
  output logic wrap_up_out,
  output logic wrap_down_out
);

  logic [16:0] low_x;
  logic [16:0] off_x;
  logic [16:0] limit_x;
  logic [16:0] size_x;
  logic [16:0] sum_x;
  logic [16:0] fixed_x;

  // One extra bit keeps the sign of the sum; offsets are two's complement
  assign low_x = {1'b0, pointer_in & mask_in};
  assign off_x = {offset_in[MAU_ADDR_W-1], offset_in};
  assign limit_x = {3'h0, size_m1_in};
  assign size_x = limit_x + 17'h0_0001;
  assign sum_x = low_x + off_x;

  // Past the top, including a start already above it, or below the base
  assign wrap_down_out = sum_x[16];
  assign wrap_up_out = !sum_x[16] && (sum_x > limit_x);

  // Only a single fold is possible, so offsets larger than the size misbehave
  always_comb begin
    if (wrap_up_out) begin
      fixed_x = sum_x - size_x;
    end else if (wrap_down_out) begin
      fixed_x = sum_x + size_x;
    end else begin
      fixed_x = sum_x;
    end
  end

  // High bits pass untouched and fix the buffer base
  assign result_out = (pointer_in & ~mask_in) | (fixed_x[15:0] & mask_in);

endmodule : mau_wrap_adder

// File: rtl/mau_modulo_address_update.sv
`timescale 1ns/1ns
module mau_modulo_address_update
  import mau_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Modifier register write port
  input wire logic mod_wr_en_in,
  input wire logic [MAU_ADDR_W-1:0] mod_wr_data_in,
  // Address request
  input wire mau_req_s req_in,
  // Modifier readback and status
  output logic [MAU_ADDR_W-1:0] modulo_modifier_out,
  output logic mod_reserved_out,
  // Address answer
  output mau_ans_s ans_out
);

  mau_state_s st_reg;
  mau_state_s st_next;

  logic [1:0] sel_w;
  logic [MAU_SIZE_W-1:0] size_m1_w;
  logic [MAU_ADDR_W-1:0] mask_w;
  logic [MAU_ADDR_W-1:0] step_w;
  logic [MAU_ADDR_W-1:0] wrapped_w;
  logic [MAU_ADDR_W-1:0] linear_w;
  logic [MAU_ADDR_W-1:0] calc_w;
  logic wrap_up_w;
  logic wrap_down_w;
  logic modulo_en;
  logic [1:0] next_sel;
  logic [MAU_SIZE_W-1:0] next_size;
  logic [MAU_ADDR_W-1:0] next_mod;

  // Fields of the live modifier; a write shows up on the next request only
  assign sel_w = st_reg.modifier[MAU_SEL_MSB:MAU_SEL_LSB];
  assign size_m1_w = st_reg.modifier[MAU_SIZE_MSB:MAU_SIZE_LSB];

  // Wrapping needs selection 00 or 10 for the first, only 10 for the second
  always_comb begin
    modulo_en = 1'b0;
    if (req_in.ptr_sel == MAU_FIRST_POINTER) begin
      modulo_en = (sel_w == MAU_SEL_FIRST) || (sel_w == MAU_SEL_BOTH);
    end else if (req_in.ptr_sel == MAU_SECOND_POINTER) begin
      modulo_en = (sel_w == MAU_SEL_BOTH);
    end else begin
      modulo_en = 1'b0;
    end
    if (sel_w == MAU_SEL_LINEAR || sel_w == MAU_SEL_RSVD) begin
      modulo_en = 1'b0;
    end
  end

  // Amount added to the pointer for each mode
  always_comb begin
    case (req_in.mode)
      MAU_MODE_INDIRECT: begin
        step_w = MAU_STEP_NONE;
      end
      MAU_MODE_POST_INC: begin
        step_w = MAU_STEP_INC;
      end
      MAU_MODE_POST_DEC: begin
        step_w = MAU_STEP_DEC;
      end
      MAU_MODE_POST_ADD, MAU_MODE_INDEX_OFS, MAU_MODE_INDEX_IMM: begin
        step_w = req_in.offset;
      end
      default: begin
        step_w = MAU_STEP_NONE;
      end
    endcase
  end

  // Buffer span rounded up to a power of two
  mau_size_mask u_mask (
    .size_m1_in(size_m1_w),
    .mask_out(mask_w)
  );

  // Single-fold modulo adder, resolved in the same cycle as the update
  mau_wrap_adder u_wrap (
    .pointer_in(req_in.pointer),
    .offset_in(step_w),
    .size_m1_in(size_m1_w),
    .mask_in(mask_w),
    .result_out(wrapped_w),
    .wrap_up_out(wrap_up_w),
    .wrap_down_out(wrap_down_w)
  );

  // Linear path for the other pointers and for disabled wrapping
  assign linear_w = req_in.pointer + step_w;
  assign calc_w = modulo_en ? wrapped_w : linear_w;

  // Modifier about to be held, built apart from st_next so no loop runs through the struct
  assign next_mod = mod_wr_en_in ? mod_wr_data_in : st_reg.modifier;
  // Reserved encodings of the value about to be held; behaviour is not defined
  assign next_sel = next_mod[MAU_SEL_MSB:MAU_SEL_LSB];
  assign next_size = next_mod[MAU_SIZE_MSB:MAU_SIZE_LSB];

  // Next state: modifier write, reserved flag and the answer
  always_comb begin
    st_next = st_reg;
    st_next.modifier = next_mod;
    st_next.reserved = 1'b0;
    case (next_sel)
      MAU_SEL_FIRST, MAU_SEL_BOTH: begin
        st_next.reserved = (next_size == MAU_SIZE_ZERO);
      end
      MAU_SEL_RSVD: begin
        st_next.reserved = 1'b1;
      end
      MAU_SEL_LINEAR: begin
        st_next.reserved = (next_size != MAU_SIZE_FULL);
      end
      default: begin
        st_next.reserved = 1'b1;
      end
    endcase
    st_next.ans = '0;
    st_next.ans.valid = req_in.valid;
    if (req_in.valid) begin
      st_next.ans.modulo = modulo_en;
      st_next.ans.wrap_up = modulo_en && wrap_up_w;
      st_next.ans.wrap_down = modulo_en && wrap_down_w;
      case (req_in.mode)
        MAU_MODE_POST_INC, MAU_MODE_POST_DEC, MAU_MODE_POST_ADD: begin
          // Access at the old pointer, then store the updated one
          st_next.ans.address = req_in.pointer;
          st_next.ans.pointer = calc_w;
          st_next.ans.write_back = 1'b1;
        end
        MAU_MODE_INDEX_OFS, MAU_MODE_INDEX_IMM: begin
          // Access at the sum, wrapped only when modulo is enabled, pointer left as it was
          st_next.ans.address = calc_w;
          st_next.ans.pointer = req_in.pointer;
          st_next.ans.write_back = 1'b0;
        end
        default: begin
          // Plain indirect: no arithmetic reaches the pointer
          st_next.ans.address = req_in.pointer;
          st_next.ans.pointer = req_in.pointer;
          st_next.ans.write_back = 1'b0;
          st_next.ans.wrap_up = 1'b0;
          st_next.ans.wrap_down = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_reg <= MAU_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign modulo_modifier_out = st_reg.modifier;
  assign mod_reserved_out = st_reg.reserved;
  assign ans_out = st_reg.ans;

  // Helpers read only by the checks below
  logic [MAU_ADDR_W-1:0] base_w;
  logic [MAU_ADDR_W-1:0] low_w;
  logic [MAU_ADDR_W-1:0] limit_w;
  logic post_mode;
  assign base_w = req_in.pointer & ~mask_w;
  assign low_w = req_in.pointer & mask_w;
  assign limit_w = {2'h0, size_m1_w};
  assign post_mode = (req_in.mode == MAU_MODE_POST_INC) || (req_in.mode == MAU_MODE_POST_DEC)
    || (req_in.mode == MAU_MODE_POST_ADD);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Pointers outside the first two always step linearly
  property p_other_linear;
    req_in.valid && req_in.ptr_sel[1] && req_in.mode == MAU_MODE_POST_INC
      |=> ans_out.pointer == 16'($past(req_in.pointer) + MAU_STEP_INC) && !ans_out.modulo;
  endproperty
  a_other_linear: assert property (p_other_linear) else $error("other pointer wrapped");

  // Top bits 11 turn wrapping off for every pointer
  property p_linear_sel;
    req_in.valid && sel_w == MAU_SEL_LINEAR |=> !ans_out.modulo && !ans_out.wrap_up;
  endproperty
  a_linear_sel: assert property (p_linear_sel) else $error("wrap with linear mode");

  // The second pointer wraps only under the both-pointer selection
  property p_second_sel;
    req_in.valid && req_in.ptr_sel == MAU_SECOND_POINTER
      |=> ans_out.modulo == ($past(sel_w) == MAU_SEL_BOTH);
  endproperty
  a_second_sel: assert property (p_second_sel) else $error("second pointer selection");

  // The first pointer wraps under selection 00
  property p_first_sel;
    req_in.valid && req_in.ptr_sel == MAU_FIRST_POINTER && sel_w == MAU_SEL_FIRST
      |=> ans_out.modulo;
  endproperty
  a_first_sel: assert property (p_first_sel) else $error("first pointer not wrapping");

  // A wrapped update keeps the high bits, so the base never moves
  sequence s_mod_post;
    req_in.valid && post_mode && modulo_en ##1 ans_out.valid;
  endsequence
  property p_base_held;
    s_mod_post |-> (ans_out.pointer & ~$past(mask_w)) == $past(base_w);
  endproperty
  a_base_held: assert property (p_base_held) else $error("buffer base moved");

  // Increment from the top of the buffer lands on the lower bound
  sequence s_inc_at_top;
    req_in.valid && modulo_en && req_in.mode == MAU_MODE_POST_INC && low_w == limit_w;
  endsequence
  property p_inc_wrap;
    s_inc_at_top |=> ans_out.pointer == $past(base_w) && ans_out.wrap_up;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment did not wrap");

  // Decrement from the lower bound lands on the upper bound
  sequence s_dec_at_base;
    req_in.valid && modulo_en && req_in.mode == MAU_MODE_POST_DEC && low_w == MAU_STEP_NONE;
  endsequence
  property p_dec_wrap;
    s_dec_at_base |=> ans_out.pointer == 16'($past(base_w) + $past(limit_w)) && ans_out.wrap_down;
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("decrement did not wrap");

  // From inside the buffer a legal offset never leaves it
  property p_in_range;
    req_in.valid && modulo_en && post_mode && low_w <= limit_w
      && (req_in.offset[15] ? 16'(-req_in.offset) : req_in.offset) <= 16'(limit_w + MAU_STEP_INC)
      |=> (ans_out.pointer & $past(mask_w)) <= $past(limit_w);
  endproperty
  a_in_range: assert property (p_in_range) else $error("pointer left buffer");

  // A start above the top has the size taken off once even with zero offset
  property p_above_top;
    req_in.valid && modulo_en && req_in.mode == MAU_MODE_POST_ADD
      && req_in.offset == MAU_STEP_NONE && low_w > limit_w
      |=> ans_out.wrap_up
        && ans_out.pointer == 16'($past(req_in.pointer) - $past(limit_w) - MAU_STEP_INC);
  endproperty
  a_above_top: assert property (p_above_top) else $error("above-top fold wrong");

  // Indexed modes wrap the address and leave the pointer alone
  property p_indexed;
    req_in.valid && modulo_en && req_in.mode == MAU_MODE_INDEX_OFS
      |=> !ans_out.write_back && ans_out.pointer == $past(req_in.pointer)
        && (ans_out.address & ~$past(mask_w)) == $past(base_w);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed update wrong");

endmodule : mau_modulo_address_update

// File: test/mau_pipe_model.sv
`timescale 1ns/1ns
// Pipeline side: a pointer file that stores each written-back pointer unless a bench load falls in the same cycle
module mau_pipe_model
  import mau_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Pointer loads from the bench
  input wire logic load_en_in,
  input wire logic [1:0] load_sel_in,
  input wire logic [15:0] load_val_in,
  // Traffic with the block
  input wire mau_req_s req_in,
  input wire mau_ans_s ans_in,
  // Pointer file
  output logic [3:0][15:0] ptr_file_out
);
  logic [1:0] sel_reg;

  // The answer lags its request by one cycle, so the pointer number is kept that long
  always_ff @(posedge clock_in) begin
    if (req_in.valid) begin
      sel_reg <= req_in.ptr_sel;
    end
    if (load_en_in) begin
      ptr_file_out[load_sel_in] <= load_val_in;
    end else if (ans_in.valid && ans_in.write_back) begin
      ptr_file_out[sel_reg] <= ans_in.pointer;
    end
  end
endmodule : mau_pipe_model

// File: test/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the modulo address update block
module tb_top;
  import mau_pkg::*;
  logic clock_in;
  logic rst_n_in;
  logic mod_wr_en_in;
  logic [15:0] mod_wr_data_in;
  mau_req_s req_in;
  logic [15:0] modulo_modifier_out;
  logic mod_reserved_out;
  mau_ans_s ans_out;
  logic load_en;
  logic [1:0] load_sel;
  logic [15:0] load_val;
  logic [3:0][15:0] ptr_file;
  mau_ans_s got;
  int bad_count;
  int num_checks;

  // Block under test and the pipeline model beside it
  mau_modulo_address_update dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .mod_wr_en_in(mod_wr_en_in),
    .mod_wr_data_in(mod_wr_data_in), .req_in(req_in),
    .modulo_modifier_out(modulo_modifier_out), .mod_reserved_out(mod_reserved_out),
    .ans_out(ans_out));
  mau_pipe_model model (
    .clock_in(clock_in), .load_en_in(load_en), .load_sel_in(load_sel),
    .load_val_in(load_val), .req_in(req_in), .ans_in(ans_out), .ptr_file_out(ptr_file));

  // Core clock, 8 ns period
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (exp !== seen) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Inputs always move one nanosecond after the edge
  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask : tick

  task automatic wr_mod(input logic [15:0] val);
    mod_wr_en_in = 1'b1;
    mod_wr_data_in = val;
    tick();
    mod_wr_en_in = 1'b0;
    chk("modifier", val, modulo_modifier_out);
    // Idle cycle so a following write never flips the strobe within one step
    tick();
  endtask : wr_mod

  task automatic load(input logic [1:0] sel, input logic [15:0] val);
    load_en = 1'b1;
    load_sel = sel;
    load_val = val;
    tick();
    load_en = 1'b0;
  endtask : load

  // One request; a second edge lets the model store the new pointer
  task automatic step(input logic [1:0] sel, input mau_mode_e mode, input logic [15:0] ofs,
                      input logic [15:0] e_addr, input logic [15:0] e_ptr);
    req_in = '{valid: 1'b1, ptr_sel: sel, mode: mode, pointer: ptr_file[sel], offset: ofs};
    tick();
    req_in.valid = 1'b0;
    got = ans_out;
    chk("ans_valid", 16'h0001, {15'h0000, got.valid});
    chk("address", e_addr, got.address);
    chk("pointer", e_ptr, got.pointer);
    tick();
    // The answer stands for one cycle only
    chk("ans_idle", 16'h0000, {15'h0000, ans_out.valid});
  endtask : step

  task automatic s_reset();
    chk("mod_reset", MAU_MOD_RESET, modulo_modifier_out);
    chk("rsv_reset", 16'h0000, {15'h0000, mod_reserved_out});
    chk("ans_reset", 16'h0000, {15'h0000, ans_out.valid});
  endtask : s_reset

  task automatic s_reserved();
    logic [15:0] vals [6] = '{16'h0000, 16'h4000, 16'h8000, 16'hc000, 16'hfffe, 16'h0004};
    for (int i = 0; i < 6; i++) begin
      wr_mod(vals[i]);
      chk("reserved", (i < 5) ? 16'h0001 : 16'h0000, {15'h0000, mod_reserved_out});
    end
  endtask : s_reserved

  task automatic s_post_inc();
    wr_mod(16'h0004);
    load(MAU_FIRST_POINTER, 16'h0800);
    for (int i = 0; i < 5; i++) begin
      step(2'h0, MAU_MODE_POST_INC, 16'h0000, 16'h0800 + 16'(i),
           (i == 4) ? 16'h0800 : 16'h0801 + 16'(i));
    end
    chk("wrap_up", 16'h0001, {15'h0000, got.wrap_up});
    chk("modulo", 16'h0001, {15'h0000, got.modulo});
  endtask : s_post_inc

  // Steps of three both ways, then a decrement from the base, stay inside the buffer with one fold
  task automatic s_post_add();
    load(MAU_FIRST_POINTER, 16'h0800);
    step(2'h0, MAU_MODE_POST_ADD, 16'h0003, 16'h0800, 16'h0803);
    step(2'h0, MAU_MODE_POST_ADD, 16'h0003, 16'h0803, 16'h0801);
    chk("wrap_up", 16'h0001, {15'h0000, got.wrap_up});
    step(2'h0, MAU_MODE_POST_ADD, 16'hfffd, 16'h0801, 16'h0803);
    chk("wrap_down", 16'h0001, {15'h0000, got.wrap_down});
    load(MAU_FIRST_POINTER, 16'h0800);
    step(2'h0, MAU_MODE_POST_DEC, 16'h0000, 16'h0800, 16'h0804);
    chk("wrap_down", 16'h0001, {15'h0000, got.wrap_down});
  endtask : s_post_add

  task automatic s_mid_start();
    load(MAU_FIRST_POINTER, 16'h0802);
    step(2'h0, MAU_MODE_POST_INC, 16'h0000, 16'h0802, 16'h0803);
    step(2'h0, MAU_MODE_POST_INC, 16'h0000, 16'h0803, 16'h0804);
    step(2'h0, MAU_MODE_POST_INC, 16'h0000, 16'h0804, 16'h0800);
  endtask : s_mid_start

  task automatic s_outside();
    wr_mod(16'h0005);
    load(MAU_FIRST_POINTER, 16'h0006);
    step(2'h0, MAU_MODE_POST_ADD, 16'h0000, 16'h0006, 16'h0000);
  endtask : s_outside

  // Both pointers wrap at 37 locations; other pointers, and the second pointer under first-only mode, stay linear
  task automatic s_both();
    wr_mod(16'h8024);
    load(MAU_SECOND_POINTER, 16'h00a4);
    step(2'h1, MAU_MODE_POST_INC, 16'h0000, 16'h00a4, 16'h0080);
    load(MAU_FIRST_POINTER, 16'h0080);
    step(2'h0, MAU_MODE_POST_DEC, 16'h0000, 16'h0080, 16'h00a4);
    load(2'h2, 16'h00a4);
    step(2'h2, MAU_MODE_POST_INC, 16'h0000, 16'h00a4, 16'h00a5);
    wr_mod(16'h0024);
    load(MAU_SECOND_POINTER, 16'h00a4);
    step(2'h1, MAU_MODE_POST_INC, 16'h0000, 16'h00a4, 16'h00a5);
  endtask : s_both

  task automatic s_linear();
    wr_mod(16'hffff);
    load(MAU_FIRST_POINTER, 16'h0804);
    step(2'h0, MAU_MODE_POST_INC, 16'h0000, 16'h0804, 16'h0805);
    chk("modulo", 16'h0000, {15'h0000, got.modulo});
  endtask : s_linear

  // Every addressing mode on a high buffer, offset two
  task automatic s_modes();
    logic [15:0] ea [6] = '{16'hf803, 16'hf803, 16'hf803, 16'hf803, 16'hf800, 16'hf800};
    logic [15:0] ep [6] = '{16'hf803, 16'hf804, 16'hf802, 16'hf800, 16'hf803, 16'hf803};
    logic [15:0] ew [6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
    wr_mod(16'h0004);
    for (int i = 0; i < 6; i++) begin
      load(MAU_FIRST_POINTER, 16'hf803);
      step(2'h0, mau_mode_e'(i), 16'h0002, ea[i], ep[i]);
      chk("write_back", ew[i], {15'h0000, got.write_back});
    end
  endtask : s_modes

  // Reset for six cycles, then the scenarios in turn
  initial begin
    bad_count = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    mod_wr_en_in = 1'b0;
    mod_wr_data_in = 16'h0000;
    req_in = '0;
    load_en = 1'b0;
    load_sel = 2'h0;
    load_val = 16'h0000;
    repeat (6) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    s_reset();
    s_reserved();
    s_post_inc();
    s_post_add();
    s_mid_start();
    s_outside();
    s_both();
    s_linear();
    s_modes();
    stop_test();
  end
endmodule : tb_top
